/* hw/hbg_uart_regs.vh */
// Constants of the host transport serial port and its baud generator.
`ifndef HBG_UART_REGS_VH
`define HBG_UART_REGS_VH

// ============================================================
// Baud register reset values, high-rate code and stuffing limit
`define HBG_DIV_RST        8'hf3
`define HBG_ADJ_RST        8'h00
`define HBG_ADJ_HIGH_RATE  8'hff
`define HBG_ADJ_MAX        4'h8

// ============================================================
// Field positions in the adjust value
`define HBG_ADJ_FIRST_LSB  0
`define HBG_ADJ_END_LSB    4

// ============================================================
// Divider structure and buffer sizes
`define HBG_OVERSAMPLE_LOG 4
`define HBG_DIV_SPAN       13'd256
`define HBG_FIFO_DEPTH     1040
`define HBG_RTS_MARGIN     16
`define HBG_DATA_BITS      8

`endif

/* hw/hbg_fifo.v */
// Byte FIFO in flip-flops with valid/ready on both sides and a fill level.
`timescale 1ns/1ps

module hbg_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 1040,
	parameter AW    = 11
) (
	input  wire             clk,
	input  wire             rst,
	input  wire [WIDTH-1:0] in_data,
	input  wire             in_valid,
	output wire             in_ready,
	output reg  [WIDTH-1:0] out_data,
	output wire             out_valid,
	input  wire             out_ready,
	output reg  [AW:0]      level
);

	reg [WIDTH-1:0] store [0:DEPTH-1];
	reg [AW-1:0]    wr_ptr;
	reg [AW-1:0]    rd_ptr;
	wire            do_push;
	wire            do_pop;

	assign in_ready  = (level != DEPTH[AW:0]);
	assign out_valid = (level != {(AW+1){1'b0}});
	assign do_push   = in_valid && in_ready;
	assign do_pop    = out_valid && out_ready;

	function [AW-1:0] bump;
		input [AW-1:0] p;
		begin
			if (p == DEPTH[AW-1:0] - 1'b1)
				bump = {AW{1'b0}};
			else
				bump = p + 1'b1;
		end
	endfunction

	always @*
	begin
		out_data = store[rd_ptr];
	end

	always @(posedge clk)
	begin
		if (do_push)
			store[wr_ptr] <= in_data;
	end

	always @(posedge clk)
	begin
		if (rst)
		begin
			wr_ptr <= {AW{1'b0}};
			rd_ptr <= {AW{1'b0}};
			level  <= {(AW+1){1'b0}};
		end
		else
		begin
			if (do_push)
				wr_ptr <= bump(wr_ptr);
			if (do_pop)
				rd_ptr <= bump(rd_ptr);
			if (do_push && !do_pop)
				level <= level + 1'b1;
			else if (do_pop && !do_push)
				level <= level - 1'b1;
		end
	end

endmodule

/* hw/hbg_uart.v */
// Host transport serial port with stuffing baud generator and two FIFOs.
`timescale 1ns/1ps
`include "hbg_uart_regs.vh"

// Operation
// - Host port has four lines: receive, transmit, request and clear to send.
// - Baud generator covers line rates from 9600 bps up to 6 Mbps.
// - Vendor command from host loads new values into the baud registers.
// - Separate 1040-byte receive and 1040-byte transmit FIFOs buffer bytes.
// - Port carries host controller traffic in H4 transport form.
// - Without reprogramming the line runs at 115.2 kbaud.
// - Baud generator clock defaults to 24 MHz after reset.
// - Low baud register divides the clock by a multiple of 16 outside high-rate mode.
// - High baud register stuffs up to eight cycles per bit half.
// - Combined host and device rate error must stay within five percent.
// - The same port also serves factory programming.
// - A second peripheral port is routed through configurable general pins.

module hbg_uart #(
	parameter FIFO_DEPTH = `HBG_FIFO_DEPTH,
	parameter FIFO_AW    = 11,
	parameter RTS_MARGIN = `HBG_RTS_MARGIN,
	parameter PIN_COUNT  = 4,
	parameter PIN_SEL_W  = 2
) (
	input  wire                 clk,
	input  wire                 rst,
	input  wire                 rxd,
	output reg                  txd,
	output reg                  rts_n,
	input  wire                 cts_n,
	input  wire                 baud_load,
	input  wire [7:0]           baud_divisor_low_in,
	input  wire [7:0]           baud_adjust_high_in,
	input  wire                 factory_mode,
	input  wire [7:0]           tx_data,
	input  wire                 tx_valid,
	output wire                 tx_ready,
	output wire [7:0]           rx_data,
	output wire                 rx_valid,
	input  wire                 rx_ready,
	output reg                  rx_is_prog,
	output reg                  rx_overrun,
	output reg                  rx_frame_err,
	input  wire                 perip_txd,
	output wire                 perip_rxd,
	input  wire [PIN_SEL_W-1:0] perip_tx_pin,
	input  wire [PIN_SEL_W-1:0] perip_rx_pin,
	input  wire [PIN_COUNT-1:0] gpio_in,
	output reg  [PIN_COUNT-1:0] gpio_out,
	output reg  [PIN_COUNT-1:0] gpio_oe
);

	// ============================================================
	// States
	localparam S_IDLE  = 4'b0001;
	localparam S_START = 4'b0010;
	localparam S_DATA  = 4'b0100;
	localparam S_STOP  = 4'b1000;

	reg  [7:0]       baud_divisor_low;
	reg  [7:0]       baud_adjust_high;
	reg  [3:0]       tx_state;
	reg  [12:0]      tx_cnt;
	reg  [7:0]       tx_shift;
	reg  [2:0]       tx_bit;
	reg  [3:0]       rx_state;
	reg  [12:0]      rx_cnt;
	reg  [7:0]       rx_shift;
	reg  [2:0]       rx_bit;
	reg              rx_push;
	wire [12:0]      bit_cycles;
	wire [12:0]      half_cycles;
	wire [7:0]       txf_data;
	wire             txf_valid;
	wire             txf_pop;
	wire             rxf_ready;
	wire [FIFO_AW:0] rx_level;

	// ============================================================
	// Baud generator
	function [3:0] clamp_stuff;
		input [3:0] n;
		begin
			clamp_stuff = (n > `HBG_ADJ_MAX) ? `HBG_ADJ_MAX : n;
		end
	endfunction

	// Whole bit time in clock cycles. The all-ones adjust value selects
	// the high-rate mode, where the divisor counts single clocks.
	function [12:0] bit_len;
		input [7:0] div;
		input [7:0] adj;
		reg   [12:0] base;
		begin
			base = `HBG_DIV_SPAN - {5'h00, div};
			if (adj == `HBG_ADJ_HIGH_RATE)
				bit_len = base;
			else
				bit_len = (base << `HBG_OVERSAMPLE_LOG)
					+ {9'h000, clamp_stuff(adj[`HBG_ADJ_FIRST_LSB +: 4])}
					+ {9'h000, clamp_stuff(adj[`HBG_ADJ_END_LSB +: 4])};
		end
	endfunction

	// Cycles from the start edge to the middle of the start bit; the
	// first-half stuffing lands before the sampling point.
	function [12:0] half_len;
		input [7:0] div;
		input [7:0] adj;
		reg   [12:0] base;
		begin
			base = `HBG_DIV_SPAN - {5'h00, div};
			if (adj == `HBG_ADJ_HIGH_RATE)
				half_len = base >> 1;
			else
				half_len = (base << (`HBG_OVERSAMPLE_LOG - 1))
					+ {9'h000, clamp_stuff(adj[`HBG_ADJ_FIRST_LSB +: 4])};
		end
	endfunction

	assign bit_cycles  = bit_len(baud_divisor_low, baud_adjust_high);
	assign half_cycles = half_len(baud_divisor_low, baud_adjust_high);

	// The system clock stands in for the 24 MHz baud clock, so the reset
	// values give 115.2 kbaud only when clk runs at 24 MHz. A load in the
	// middle of a character bends that character; the host must wait for
	// the line to go quiet before it changes the rate.
	always @(posedge clk)
	begin
		if (rst)
		begin
			baud_divisor_low <= `HBG_DIV_RST;
			baud_adjust_high <= `HBG_ADJ_RST;
		end
		else if (baud_load)
		begin
			baud_divisor_low <= baud_divisor_low_in;
			baud_adjust_high <= baud_adjust_high_in;
		end
	end

	// ============================================================
	// FIFOs
	hbg_fifo #(
		.WIDTH (8),
		.DEPTH (FIFO_DEPTH),
		.AW    (FIFO_AW)
	) u_tx_fifo (
		.clk       (clk),
		.rst       (rst),
		.in_data   (tx_data),
		.in_valid  (tx_valid),
		.in_ready  (tx_ready),
		.out_data  (txf_data),
		.out_valid (txf_valid),
		.out_ready (txf_pop),
		.level     ()
	);

	hbg_fifo #(
		.WIDTH (8),
		.DEPTH (FIFO_DEPTH),
		.AW    (FIFO_AW)
	) u_rx_fifo (
		.clk       (clk),
		.rst       (rst),
		.in_data   (rx_shift),
		.in_valid  (rx_push),
		.in_ready  (rxf_ready),
		.out_data  (rx_data),
		.out_valid (rx_valid),
		.out_ready (rx_ready),
		.level     (rx_level)
	);

	// ============================================================
	// Transmitter
	assign txf_pop = (tx_state == S_IDLE) && txf_valid && !cts_n;

	always @(posedge clk)
	begin
		if (rst)
		begin
			tx_state <= S_IDLE;
			tx_cnt   <= 13'h0000;
			tx_shift <= 8'h00;
			tx_bit   <= 3'h0;
			txd      <= 1'b1;
		end
		else
		begin
			case (tx_state)
			S_IDLE:
			begin
				txd <= 1'b1;
				if (txf_pop)
				begin
					tx_shift <= txf_data;
					tx_cnt   <= bit_cycles - 1'b1;
					txd      <= 1'b0;
					tx_state <= S_START;
				end
			end
			S_START, S_DATA:
			begin
				if (tx_cnt == 13'h0000)
				begin
					tx_cnt <= bit_cycles - 1'b1;
					if (tx_state == S_DATA && tx_bit == 3'h7)
					begin
						txd      <= 1'b1;
						tx_state <= S_STOP;
					end
					else
					begin
						if (tx_state == S_DATA)
							tx_bit <= tx_bit + 1'b1;
						else
							tx_bit <= 3'h0;
						txd      <= tx_shift[0];
						tx_shift <= {1'b0, tx_shift[7:1]};
						tx_state <= S_DATA;
					end
				end
				else
					tx_cnt <= tx_cnt - 1'b1;
			end
			S_STOP:
			begin
				if (tx_cnt == 13'h0000)
					tx_state <= S_IDLE;
				else
					tx_cnt <= tx_cnt - 1'b1;
			end
			default:
			begin
				tx_state <= S_IDLE;
				txd      <= 1'b1;
			end
			endcase
		end
	end

	// ============================================================
	// Receiver
	// Sampling in the middle of each bit leaves half a bit of slack
	// across a whole frame, which covers the combined rate error.
	always @(posedge clk)
	begin
		if (rst)
		begin
			rx_state     <= S_IDLE;
			rx_cnt       <= 13'h0000;
			rx_shift     <= 8'h00;
			rx_bit       <= 3'h0;
			rx_push      <= 1'b0;
			rx_overrun   <= 1'b0;
			rx_frame_err <= 1'b0;
			rx_is_prog   <= 1'b0;
		end
		else
		begin
			rx_push      <= 1'b0;
			rx_overrun   <= 1'b0;
			rx_frame_err <= 1'b0;
			case (rx_state)
			S_IDLE:
			begin
				if (!rxd)
				begin
					rx_cnt   <= half_cycles - 1'b1;
					rx_state <= S_START;
				end
			end
			S_START:
			begin
				if (rx_cnt != 13'h0000)
					rx_cnt <= rx_cnt - 1'b1;
				else if (rxd)
					rx_state <= S_IDLE;
				else
				begin
					rx_cnt   <= bit_cycles - 1'b1;
					rx_bit   <= 3'h0;
					rx_state <= S_DATA;
				end
			end
			S_DATA:
			begin
				if (rx_cnt != 13'h0000)
					rx_cnt <= rx_cnt - 1'b1;
				else
				begin
					rx_shift <= {rxd, rx_shift[7:1]};
					rx_cnt   <= bit_cycles - 1'b1;
					rx_bit   <= rx_bit + 1'b1;
					if (rx_bit == 3'h7)
						rx_state <= S_STOP;
				end
			end
			S_STOP:
			begin
				if (rx_cnt != 13'h0000)
					rx_cnt <= rx_cnt - 1'b1;
				else
				begin
					rx_state <= S_IDLE;
					if (!rxd)
						rx_frame_err <= 1'b1;
					else if (!rxf_ready)
						rx_overrun <= 1'b1;
					else
					begin
						rx_push    <= 1'b1;
						rx_is_prog <= factory_mode;
					end
				end
			end
			default:
				rx_state <= S_IDLE;
			endcase
		end
	end

	// ============================================================
	// Flow control
	always @(posedge clk)
	begin
		if (rst)
			rts_n <= 1'b1;
		else
			rts_n <= (rx_level >= FIFO_DEPTH - RTS_MARGIN);
	end

	// ============================================================
	// Peripheral port pin routing
	assign perip_rxd = gpio_in[perip_rx_pin];

	always @(posedge clk)
	begin
		if (rst)
		begin
			gpio_out <= {PIN_COUNT{1'b1}};
			gpio_oe  <= {PIN_COUNT{1'b0}};
		end
		else
		begin
			gpio_out <= {PIN_COUNT{1'b1}};
			gpio_oe  <= {PIN_COUNT{1'b0}};
			gpio_out[perip_tx_pin] <= perip_txd;
			gpio_oe[perip_tx_pin]  <= 1'b1;
		end
	end

endmodule

/* verification/hbg_uart_monitor.sv */
// Checker of the host serial port pins, flags and pin routing.
`timescale 1ns/1ps
module hbg_uart_monitor #(
	parameter PIN_COUNT = 4,
	parameter PIN_SEL_W = 2
) (
	input wire                 clk,
	input wire                 rst,
	input wire                 rxd,
	input wire                 txd,
	input wire                 rts_n,
	input wire                 cts_n,
	input wire                 rx_valid,
	input wire                 rx_overrun,
	input wire                 rx_frame_err,
	input wire                 perip_txd,
	input wire                 perip_rxd,
	input wire [PIN_SEL_W-1:0] perip_tx_pin,
	input wire [PIN_SEL_W-1:0] perip_rx_pin,
	input wire [PIN_COUNT-1:0] gpio_in,
	input wire [PIN_COUNT-1:0] gpio_out,
	input wire [PIN_COUNT-1:0] gpio_oe
);
	// ====
	// A fall after a long high run can only be a start bit, because no
	// frame holds more than eight high bits ahead of its stop bit.
	logic [11:0] hi_run;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	always @(posedge clk)
		hi_run <= (rst || !txd) ? 12'h000 : hi_run + {11'h000, ~&hi_run};
	reset_state_a: assert property
		($fell(rst) |-> txd && rts_n && !gpio_oe && !rx_valid)
		else $error("bad state after reset");
	rts_release_a: assert property ($fell(rst) |=> !rts_n)
		else $error("rts not low after reset");
	cts_gate_a: assert property
		($fell(txd) && hi_run > 12'd1700 |-> !$past(cts_n))
		else $error("start bit while cts high");
	rx_push_a: assert property
		($rose(rx_valid) |-> $past(rxd) || $past(rxd, 2))
		else $error("byte kept without stop bit");
	frame_err_a: assert property
		(rx_frame_err |-> !$past(rxd) || !$past(rxd, 2))
		else $error("frame error with good stop bit");
	overrun_full_a: assert property (rx_overrun |-> rx_valid && rts_n)
		else $error("overrun without full buffer");
	err_pulse_a: assert property
		(rx_frame_err || rx_overrun |=> !rx_frame_err && !rx_overrun)
		else $error("error flag longer than one cycle");
	gpio_route_a: assert property
		(!$past(rst) |-> gpio_oe == 1 << $past(perip_tx_pin))
		else $error("wrong pin enabled");
	gpio_drive_a: assert property (!$past(rst) |-> gpio_out ==
		(~gpio_oe | {PIN_COUNT{$past(perip_txd)}} & gpio_oe))
		else $error("wrong pin level");
	perip_rx_a: assert property (perip_rxd == gpio_in[perip_rx_pin])
		else $error("wrong receive pin");
endmodule
bind hbg_uart hbg_uart_monitor #(.PIN_COUNT(PIN_COUNT), .PIN_SEL_W(PIN_SEL_W))
	i_mon (.clk, .rst, .rxd, .txd, .rts_n, .cts_n, .rx_valid, .rx_overrun,
	.rx_frame_err, .perip_txd, .perip_rxd, .perip_tx_pin, .perip_rx_pin,
	.gpio_in, .gpio_out, .gpio_oe);

/* verification/hbg_host_model.sv */
// Host end of the serial link: sends and receives whole characters.
`timescale 1ns/1ps
module hbg_host_model (
	input  wire        clk,
	input  wire  [7:0] bit_t,
	input  wire        txd,
	input  wire        rts_n,
	output logic       rxd,
	output logic       got,
	output logic [7:0] got_byte,
	output logic       got_stop
);
	// ====
	// The host runs at exactly the device bit time, so the combined rate
	// error is zero.
	logic [7:0] r;
	initial
	begin
		rxd = 1'b1;
		got = 1'b0;
		forever
		begin
			@(negedge txd);
			repeat (bit_t / 2) @(posedge clk);
			for (int i = 0; i < 9; i++)
			begin
				repeat (bit_t) @(posedge clk);
				if (i < 8)
					r = {txd, r[7:1]};
				else
					got_stop = txd;
			end
			#1 got_byte = r;
			got = 1'b1;
			@(posedge clk);
			#1 got = 1'b0;
		end
	end
	task send_char(input logic [7:0] d, input logic ok, input logic ign);
		logic [9:0] f;
		f = {ok, d, 1'b0};
		while (rts_n && !ign) @(posedge clk);
		for (int i = 0; i < 10; i++)
		begin
			@(posedge clk);
			#1 rxd = f[i];
			repeat (bit_t - 1) @(posedge clk);
		end
		@(posedge clk);
		#1 rxd = 1'b1;
		repeat (bit_t) @(posedge clk);
		#1;
	endtask
endmodule

/* verification/tb.sv */
// Self-checking bench of the host serial port against a host model.
`timescale 1ns/1ps
`define CHK(a, b) \
	begin \
		samples_checked++; \
		if ((a) !== (b)) \
		begin \
			miscompares++; \
			$display("[ERR] %0t got %h want %h", $time, a, b); \
		end \
	end
module tb;
	logic       clk, rst, cts_n, baud_load, factory_mode, tx_valid;
	logic       rx_ready, perip_txd;
	logic [7:0] tx_data, baud_divisor_low_in, baud_adjust_high_in, bit_t;
	logic [1:0] perip_tx_pin, perip_rx_pin;
	logic [3:0] gpio_in, eg;
	logic [8:0] er;
	logic [7:0] et;
	wire        rxd, txd, rts_n, tx_ready, rx_valid, rx_is_prog, got, got_stop;
	wire        rx_overrun, rx_frame_err, perip_rxd;
	wire  [7:0] rx_data, got_byte;
	wire  [3:0] gpio_out, gpio_oe;
	logic [8:0] exp_rx[$];
	logic [7:0] exp_tx[$];
	int         miscompares, samples_checked, cyc, ferr, oerr;
	int unsigned seed = 88;
	// Divisor, adjust and resulting bit time in clock cycles.
	localparam logic [23:0] cfg [4] = '{24'hff0010, 24'hfe4428,
		24'hff9f20, 24'hfcff04};
	hbg_uart #(.FIFO_DEPTH(32), .FIFO_AW(5), .RTS_MARGIN(4)) i_hbg_uart (.*);
	hbg_host_model i_hbg_host_model (.*);
	always #25 clk = ~clk;
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	task complete_run();
		if (miscompares == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task push(input int n);
		@(posedge clk);
		#1;
		repeat (n)
		begin
			tx_data = rnd();
			tx_valid = 1'b1;
			@(posedge clk);
			if (tx_ready === 1'b1)
				exp_tx.push_back(tx_data);
			#1;
		end
		tx_valid = 1'b0;
	endtask
	task host(input logic [7:0] d, input logic ok, input logic keep);
		if (keep)
			exp_rx.push_back({factory_mode, d});
		i_hbg_host_model.send_char(d, ok, !rx_ready);
	endtask
	task drain();
		while (exp_rx.size() || exp_tx.size()) @(posedge clk);
		#1;
	endtask
	task load(input logic [23:0] c);
		{baud_divisor_low_in, baud_adjust_high_in, bit_t} = c;
		baud_load = 1'b1;
		@(posedge clk);
		#1 baud_load = 1'b0;
	endtask
	// ====
	// Output checks and the run limit.
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			miscompares++;
			complete_run();
		end
		ferr += (rx_frame_err === 1'b1);
		oerr += (rx_overrun === 1'b1);
		if (rx_valid === 1'b1 && rx_ready === 1'b1)
		begin
			`CHK(exp_rx.size() > 0, 1'b1)
			er = exp_rx.pop_front();
			`CHK({rx_is_prog, rx_data}, er)
		end
		if (got === 1'b1)
		begin
			`CHK(exp_tx.size() > 0, 1'b1)
			et = exp_tx.pop_front();
			`CHK({got_stop, got_byte}, {1'b1, et})
		end
	end
	initial
	begin
		{clk, cts_n, baud_load, factory_mode, tx_valid, perip_txd} = 6'h00;
		{tx_data, baud_divisor_low_in, baud_adjust_high_in} = 24'h000000;
		{perip_tx_pin, perip_rx_pin, gpio_in} = 8'h00;
		rst = 1'b1;
		rx_ready = 1'b1;
		bit_t = 8'd208;
		repeat (20) @(posedge clk);
		#1 rst = 1'b0;
		push(2);
		host(8'h01, 1'b1, 1'b1);
		drain();
		foreach (cfg[k])
		begin
			load(cfg[k]);
			factory_mode = k[0];
			push(2);
			host(rnd(), 1'b1, 1'b1);
			drain();
		end
		host(rnd(), 1'b0, 1'b0);
		`CHK(ferr, 1)
		cts_n = 1'b1;
		// A long quiet line lets the start-bit assertion see any start
		// that the transmitter makes while cts_n is high.
		repeat (1800) @(posedge clk);
		push(33);
		`CHK(tx_ready, 1'b0)
		repeat (1800) @(posedge clk);
		`CHK(exp_tx.size(), 32)
		#1 cts_n = 1'b0;
		drain();
		rx_ready = 1'b0;
		repeat (33) host(rnd(), 1'b1, exp_rx.size() < 32);
		`CHK(oerr, 1)
		`CHK(rts_n, 1'b1)
		rx_ready = 1'b1;
		drain();
		repeat (4) @(posedge clk);
		`CHK(rts_n, 1'b0)
		#1;
		repeat (4)
		begin
			{perip_tx_pin, perip_rx_pin, gpio_in} = rnd();
			perip_txd = seed[9];
			@(posedge clk);
			#1;
			eg = 4'h1 << perip_tx_pin;
			`CHK(perip_rxd, gpio_in[perip_rx_pin])
			`CHK(gpio_oe, 4'h1 << perip_tx_pin)
			`CHK(gpio_out, ~eg | ({4{perip_txd}} & eg))
		end
		complete_run();
	end
endmodule
